// ===== fault_code_defs.svh
`ifndef FAULT_CODE_DEFS_SVH
`define FAULT_CODE_DEFS_SVH

// ----------------------------------------
// timing
// ----------------------------------------
`define CLK_HZ           40000000
`define IN_LOSS_TIME_MS  1000

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define ADDR_CTRL        8'h00
`define ADDR_STATUS      8'h04
`define ADDR_INT_STAT    8'h08
`define ADDR_INT_MASK    8'h0c
`define ADDR_FAULT_RST   8'h10

// ----------------------------------------
// control fields and reset values
// ----------------------------------------
`define CTRL_SEL_LSB     0
`define CTRL_OUT_EN_BIT  2
`define CTRL_IN_EN_BIT   3
`define CTRL_PFS_LSB     4
`define SEL_RST          2'h0
`define OUT_EN_RST       1'b1
`define IN_EN_RST        1'b0
`define PFS_RST          2'h0

// ----------------------------------------
// interrupt bits
// ----------------------------------------
`define INT_FAULT        0
`define INT_IN_TRIP      1
`define INT_OUT_TRIP     2
`define INT_PF_DECEL     3
`define INT_SHUTOFF      4

// ----------------------------------------
// fault input positions
// ----------------------------------------
`define FLT_OC_ACCEL     0
`define FLT_OC_CONST     1
`define FLT_OC_DECEL     2
`define FLT_OVERVOLT     3
`define FLT_MOTOR_THM    4
`define FLT_TRANS_THM    5
`define FLT_POWER_DIP    6
`define FLT_UNDERVOLT    7
`define FLT_HEATSINK     8
`define FLT_BRAKE        9
`define FLT_GROUND       10
`define FLT_EXT_THM      11
`define FLT_STALL        12
`define FLT_OPTION       13
`define FLT_OPT_SLOT     14

// ----------------------------------------
// fault codes
// ----------------------------------------
`define CODE_NORMAL      4'h0
`define CODE_OC_ACCEL    4'h1
`define CODE_OC_CONST    4'h2
`define CODE_OC_DECEL    4'h3
`define CODE_OVERVOLT    4'h4
`define CODE_MOTOR_THM   4'h5
`define CODE_TRANS_THM   4'h6
`define CODE_POWER_DIP   4'h7
`define CODE_UNDERVOLT   4'h8
`define CODE_HEATSINK    4'h9
`define CODE_BRAKE       4'ha
`define CODE_GROUND      4'hb
`define CODE_EXT_THM     4'hc
`define CODE_STALL       4'hd
`define CODE_OPTION      4'he
`define CODE_OTHER       4'hf

`endif

// ===== fault_code_pkg.sv
package fault_code_pkg;

    typedef enum logic [1:0] {SEL_OFF, SEL_ALWAYS, SEL_ON_FAULT, SEL_RSVD} code_sel_e;

    typedef struct packed {
        logic [3:0]  sync1;
        logic [3:0]  sync2;
        code_sel_e   sel;
        logic        out_en;
        logic        in_en;
        logic [1:0]  pfs;
        logic        latched;
        logic [3:0]  code;
        logic [31:0] cnt;
        logic        in_trip;
        logic        out_trip;
        logic        pf_decel;
        logic        shutoff;
        logic [4:0]  int_stat;
        logic [4:0]  int_mask;
        logic        irq;
        logic [3:0]  term;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } state_s;

endpackage : fault_code_pkg

// ===== fault_code_output.sv
// What this block does
// [R1] select 0: no code; terminals carry their assigned normal functions
// [R2] select 1: code always driven; zero while no fault
// [R3] select 2: code only during a fault; assigned functions otherwise
// [R4] 4-bit code, bit3 most significant; 1 turns the transistor on
// [R5] fixed mapping of each known fault to codes 1 to E
// [R6] any unlisted fault gives code F, all outputs on
// [R7] select 1 or 2 plus fault: code overrides the function assignment
// [R8] output phase loss enable resets to 1; 0 suppresses that trip
// [R9] input phase loss enable resets to 0; no trip while 0
// [R10] input phase loss trips only after 1 s of continuous loss
// [R11] nonzero power-fail stop: decelerate instead of input loss trip
// [R12] loss of first and second phases: shut output off, no trip
// [R13] code held while fault latched; normal content only after reset
`include "fault_code_defs.svh"

module fault_code_output #(
    parameter int unsigned IN_LOSS_CYC = `IN_LOSS_TIME_MS * (`CLK_HZ / 1000)
) (
    // clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    // drive fault sources and assigned terminal functions
    input  wire logic [15:0] fault_i,
    input  wire logic [3:0]  normal_sig_i,
    // phase loss pins (asynchronous)
    input  wire logic        out_phase_lost_i,
    input  wire logic [2:0]  in_phase_lost_i,
    // open-collector terminals, 1 = transistor on
    output logic             code_bit3_o,
    output logic             code_bit2_o,
    output logic             code_bit1_o,
    output logic             code_bit0_o,
    // drive actions
    output logic             trip_o,
    output logic             pf_decel_o,
    output logic             out_shutoff_o,
    output logic             irq_o
);

    fault_code_pkg::state_s s_r;
    fault_code_pkg::state_s s_nxt;

    // ----------------------------------------
    // fault priority encoder
    // ----------------------------------------
    function automatic logic [3:0] encode(input logic [15:0] f);
        logic [3:0] c;
        c = `CODE_OTHER; // R6
        if (f[`FLT_OC_ACCEL])       c = `CODE_OC_ACCEL; // R5
        else if (f[`FLT_OC_CONST])  c = `CODE_OC_CONST;
        else if (f[`FLT_OC_DECEL])  c = `CODE_OC_DECEL;
        else if (f[`FLT_OVERVOLT])  c = `CODE_OVERVOLT;
        else if (f[`FLT_MOTOR_THM]) c = `CODE_MOTOR_THM;
        else if (f[`FLT_TRANS_THM]) c = `CODE_TRANS_THM;
        else if (f[`FLT_POWER_DIP]) c = `CODE_POWER_DIP;
        else if (f[`FLT_UNDERVOLT]) c = `CODE_UNDERVOLT;
        else if (f[`FLT_HEATSINK])  c = `CODE_HEATSINK;
        else if (f[`FLT_BRAKE])     c = `CODE_BRAKE;
        else if (f[`FLT_GROUND])    c = `CODE_GROUND;
        else if (f[`FLT_EXT_THM])   c = `CODE_EXT_THM;
        else if (f[`FLT_STALL])     c = `CODE_STALL;
        else if (f[`FLT_OPTION] || f[`FLT_OPT_SLOT])
            c = `CODE_OPTION;
        return c;
    endfunction : encode

    // ----------------------------------------
    // combinational next state
    // ----------------------------------------
    logic        wr;
    logic        rd;
    logic        fault_rst;
    logic        in_detect;
    logic        rs_lost;
    logic        in_done;
    logic        out_hit;
    logic [15:0] fault_all;
    logic [4:0]  ev;

    always_comb
    begin
        s_nxt = s_r;
        wr = psel_i && penable_i && s_r.pready && pwrite_i;
        rd = psel_i && penable_i && !s_r.pready && !pwrite_i;
        fault_rst = wr && (paddr_i == `ADDR_FAULT_RST) && pwdata_i[0];

        s_nxt.sync1 = {out_phase_lost_i, in_phase_lost_i};
        s_nxt.sync2 = s_r.sync1;

        rs_lost = s_r.sync2[0] && s_r.sync2[1];
        in_detect = s_r.in_en && (|s_r.sync2[2:0]) && !rs_lost; // R9
        s_nxt.shutoff = s_r.in_en && rs_lost; // R12

        // continuous-loss timer, restarts on any gap
        in_done = 1'b0;
        if (!in_detect || s_r.in_trip || s_r.pf_decel)
            s_nxt.cnt = 32'h0;
        else if (s_r.cnt == IN_LOSS_CYC - 1)
            in_done = 1'b1; // R10
        else
            s_nxt.cnt = s_r.cnt + 32'h1;

        if (in_done && s_r.pfs != 2'h0)
            s_nxt.pf_decel = 1'b1; // R11
        if (in_done && s_r.pfs == 2'h0)
            s_nxt.in_trip = 1'b1; // R10

        out_hit = s_r.out_en && s_r.sync2[3]; // R8
        if (out_hit)
            s_nxt.out_trip = 1'b1;

        // latch first fault and hold it until reset
        fault_all = fault_i;
        if (s_r.in_trip || s_r.out_trip)
            fault_all[15] = 1'b1;
        if (!s_r.latched && (|fault_all))
        begin
            s_nxt.latched = 1'b1; // R13
            s_nxt.code = encode(fault_all); // R5 R6
        end
        if (fault_rst)
        begin
            s_nxt.latched = 1'b0; // R13
            s_nxt.code = `CODE_NORMAL;
            s_nxt.in_trip = 1'b0;
            s_nxt.out_trip = 1'b0;
            s_nxt.pf_decel = 1'b0;
        end

        // terminal content
        case (s_r.sel)
            fault_code_pkg::SEL_ALWAYS:
                s_nxt.term = s_r.latched ? s_r.code : `CODE_NORMAL; // R2
            fault_code_pkg::SEL_ON_FAULT:
                s_nxt.term = s_r.latched ? s_r.code : normal_sig_i; // R3 R7
            default:
                s_nxt.term = normal_sig_i; // R1
        endcase

        // sticky events, set wins over clear
        ev = '0;
        ev[`INT_FAULT] = !s_r.latched && s_nxt.latched;
        ev[`INT_IN_TRIP] = !s_r.in_trip && s_nxt.in_trip;
        ev[`INT_OUT_TRIP] = !s_r.out_trip && s_nxt.out_trip;
        ev[`INT_PF_DECEL] = !s_r.pf_decel && s_nxt.pf_decel;
        ev[`INT_SHUTOFF] = !s_r.shutoff && s_nxt.shutoff;
        if (wr && paddr_i == `ADDR_INT_STAT)
            s_nxt.int_stat = s_r.int_stat & ~pwdata_i[4:0];
        s_nxt.int_stat = s_nxt.int_stat | ev;
        s_nxt.irq = |(s_nxt.int_stat & s_nxt.int_mask);

        // register writes
        if (wr && paddr_i == `ADDR_CTRL)
        begin
            s_nxt.sel = fault_code_pkg::code_sel_e'(pwdata_i[`CTRL_SEL_LSB +: 2]);
            s_nxt.out_en = pwdata_i[`CTRL_OUT_EN_BIT];
            s_nxt.in_en = pwdata_i[`CTRL_IN_EN_BIT];
            s_nxt.pfs = pwdata_i[`CTRL_PFS_LSB +: 2];
        end
        if (wr && paddr_i == `ADDR_INT_MASK)
            s_nxt.int_mask = pwdata_i[4:0];
        s_nxt.irq = |(s_nxt.int_stat & s_nxt.int_mask);

        // apb: one wait state, answer in second access cycle
        s_nxt.pready = psel_i && penable_i && !s_r.pready;
        s_nxt.pslverr = 1'b0;
        s_nxt.prdata = 32'h0;
        if (psel_i && penable_i && !s_r.pready)
        begin
            case (paddr_i)
                `ADDR_CTRL:
                    s_nxt.prdata = {26'h0, s_r.pfs, s_r.in_en, s_r.out_en, s_r.sel};
                `ADDR_STATUS:
                    s_nxt.prdata = {23'h0, s_r.shutoff, s_r.pf_decel, s_r.out_trip,
                                    s_r.in_trip, s_r.latched, s_r.code};
                `ADDR_INT_STAT:
                    s_nxt.prdata = {27'h0, s_r.int_stat};
                `ADDR_INT_MASK:
                    s_nxt.prdata = {27'h0, s_r.int_mask};
                `ADDR_FAULT_RST:
                    s_nxt.prdata = 32'h0;
                default:
                    s_nxt.pslverr = 1'b1;
            endcase
            if (!rd)
                s_nxt.prdata = 32'h0;
        end
    end

    // ----------------------------------------
    // state register
    // ----------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s_r <= '0;
            s_r.sel <= fault_code_pkg::code_sel_e'(`SEL_RST);
            s_r.out_en <= `OUT_EN_RST; // R8
            s_r.in_en <= `IN_EN_RST; // R9
            s_r.pfs <= `PFS_RST;
        end
        else
            s_r <= s_nxt;
    end

    // ----------------------------------------
    // outputs
    // ----------------------------------------
    assign code_bit3_o = s_r.term[3]; // R4
    assign code_bit2_o = s_r.term[2];
    assign code_bit1_o = s_r.term[1];
    assign code_bit0_o = s_r.term[0];
    assign trip_o = s_r.latched;
    assign pf_decel_o = s_r.pf_decel;
    assign out_shutoff_o = s_r.shutoff;
    assign irq_o = s_r.irq;
    assign prdata_o = s_r.prdata;
    assign pready_o = s_r.pready;
    assign pslverr_o = s_r.pslverr;

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    logic [3:0] term_w;
    assign term_w = {code_bit3_o, code_bit2_o, code_bit1_o, code_bit0_o};

    sequence s_latched_fault;
        s_r.latched ##1 s_r.latched;
    endsequence

    property p_sel_off;
        s_r.sel == fault_code_pkg::SEL_OFF |=> term_w == $past(normal_sig_i);
    endproperty
    a_sel_off: assert property (p_sel_off) else $error("select 0 drove code"); // R1

    property p_sel_always_idle;
        s_r.sel == fault_code_pkg::SEL_ALWAYS && !s_r.latched |=> term_w == 4'h0;
    endproperty
    a_sel_always_idle: assert property (p_sel_always_idle) else $error("idle code not zero"); // R2

    property p_sel_fault_idle;
        s_r.sel == fault_code_pkg::SEL_ON_FAULT && !s_r.latched
            |=> term_w == $past(normal_sig_i);
    endproperty
    a_sel_fault_idle: assert property (p_sel_fault_idle) else $error("normal signal lost"); // R3

    property p_override;
        s_r.sel != fault_code_pkg::SEL_OFF && s_r.sel != fault_code_pkg::SEL_RSVD
            && s_r.latched |=> term_w == $past(s_r.code);
    endproperty
    a_override: assert property (p_override) else $error("code not on terminals"); // R7

    property p_map_oc;
        !s_r.latched && fault_i[`FLT_OC_ACCEL] |=> s_r.code == 4'h1;
    endproperty
    a_map_oc: assert property (p_map_oc) else $error("wrong accel overcurrent code"); // R5

    property p_map_other;
        !s_r.latched && fault_i == 16'h8000 |=> s_r.code == 4'hf;
    endproperty
    a_map_other: assert property (p_map_other) else $error("unlisted fault not F"); // R6

    property p_out_loss_off;
        !s_r.out_en |=> !($rose(s_r.out_trip));
    endproperty
    a_out_loss_off: assert property (p_out_loss_off) else $error("output loss trip while off"); // R8

    property p_in_loss_off;
        !s_r.in_en |=> !$rose(s_r.in_trip) && !$rose(s_r.pf_decel);
    endproperty
    a_in_loss_off: assert property (p_in_loss_off) else $error("input loss action while off"); // R9

    property p_in_timer;
        $rose(s_r.in_trip) |-> $past(s_r.cnt) == IN_LOSS_CYC - 1 && $past(s_r.pfs) == 2'h0;
    endproperty
    a_in_timer: assert property (p_in_timer) else $error("input trip before 1 s"); // R10

    property p_pf_decel;
        $rose(s_r.pf_decel) |-> $past(s_r.pfs) != 2'h0 && !s_r.in_trip;
    endproperty
    a_pf_decel: assert property (p_pf_decel) else $error("decel without stop select"); // R11

    property p_rs_shutoff;
        s_r.in_en && s_r.sync2[1:0] == 2'b11 |=> out_shutoff_o && !$rose(s_r.in_trip);
    endproperty
    a_rs_shutoff: assert property (p_rs_shutoff) else $error("phase pair loss mishandled"); // R12

    property p_hold;
        s_latched_fault |-> s_r.code == $past(s_r.code);
    endproperty
    a_hold: assert property (p_hold) else $error("latched code changed"); // R13

endmodule : fault_code_output

// ===== plc_code_reader.sv
// -------
// controller side: reads the four terminals as one code
// -------
module plc_code_reader (
    // clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // open-collector terminals, 1 = transistor on
    input  wire logic       bit3_i,
    input  wire logic       bit2_i,
    input  wire logic       bit1_i,
    input  wire logic       bit0_i,
    // code as read
    output logic      [3:0] code_o
);
    timeunit 1ns;
    timeprecision 1ps;

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
            code_o <= 4'h0;
        else
            code_o <= {bit3_i, bit2_i, bit1_i, bit0_i};
    end
endmodule : plc_code_reader

// ===== test_fault_code_output.sv
`include "fault_code_defs.svh"

module test_fault_code_output;
    timeunit 1ns;
    timeprecision 1ps;

    // -------
    // signals
    // -------
    logic        clk_i;
    logic        rst_i;
    logic        psel;
    logic        pen;
    logic        pwr;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [15:0] fault;
    logic [3:0]  normal;
    logic        out_lost;
    logic [2:0]  in_lost;
    logic [3:0]  bits;
    logic        trip;
    logic        decel;
    logic        shutoff;
    logic        irq;
    logic [3:0]  code_seen;
    logic [31:0] rd;
    logic        err;
    int          error_cnt = 0;
    int          check_count = 0;
    int          cyc = 0;
    logic [3:0]  exp_code [16] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8,
                                   4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'he, 4'hf};

    fault_code_output #(.IN_LOSS_CYC(16)) u_fault_code_output (
        .clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
        .pslverr_o(pslverr), .fault_i(fault), .normal_sig_i(normal),
        .out_phase_lost_i(out_lost), .in_phase_lost_i(in_lost),
        .code_bit3_o(bits[3]), .code_bit2_o(bits[2]), .code_bit1_o(bits[1]),
        .code_bit0_o(bits[0]), .trip_o(trip), .pf_decel_o(decel),
        .out_shutoff_o(shutoff), .irq_o(irq));

    plc_code_reader u_plc_code_reader (
        .clk_i(clk_i), .rst_i(rst_i), .bit3_i(bits[3]), .bit2_i(bits[2]),
        .bit1_i(bits[1]), .bit0_i(bits[0]), .code_o(code_seen));

    initial
    begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    always @(posedge clk_i)
    begin
        cyc <= cyc + 1;
        if (cyc == 6000)
        begin
            error_cnt++;
            tally_and_finish();
        end
    end

    // -------
    // shared tasks
    // -------
    task tally_and_finish;
        if (error_cnt == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : tally_and_finish

    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task waitc(input int n);
        repeat (n) @(posedge clk_i);
    endtask : waitc

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        psel   <= 1'b1;
        pwr    <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge clk_i);
        pen <= 1'b1;
        do @(posedge clk_i); while (pready !== 1'b1);
        rd  = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen  <= 1'b0;
    endtask : apb

    task clear_fault;
        fault    <= 16'h0;
        in_lost  <= 3'h0;
        out_lost <= 1'b0;
        waitc(3);
        apb(1'b1, `ADDR_FAULT_RST, 32'h1);
        waitc(5);
    endtask : clear_fault

    // -------
    // scenarios
    // -------
    task t_sel_off;
        apb(1'b0, `ADDR_CTRL, 32'h0);
        check("ctrl_rst", rd, 32'h4);
        normal <= 4'ha;
        fault  <= 16'h0001;
        waitc(5);
        check("term_off", code_seen, 4'ha);
        check("trip_off", trip, 1'b1);
        apb(1'b1, `ADDR_CTRL, 32'h7);
        waitc(4);
        check("term_rsvd", code_seen, 4'ha);
        clear_fault();
    endtask : t_sel_off

    task t_map;
        apb(1'b1, `ADDR_CTRL, 32'h5);
        waitc(5);
        check("term_idle", code_seen, 4'h0);
        for (int i = 0; i < 16; i++)
        begin
            fault <= 16'h1 << i;
            waitc(5);
            check("code", code_seen, exp_code[i]);
            fault <= 16'hffff;
            waitc(4);
            check("code_held", code_seen, exp_code[i]);
            clear_fault();
            check("term_clr", code_seen, 4'h0);
        end
    endtask : t_map

    task t_sel_on_fault;
        apb(1'b1, `ADDR_CTRL, 32'h6);
        waitc(5);
        check("term_norm", code_seen, 4'ha);
        fault <= 16'h0400;
        waitc(5);
        check("term_flt", code_seen, 4'hb);
        fault <= 16'h0;
        waitc(5);
        check("term_hold", code_seen, 4'hb);
        clear_fault();
        check("term_back", code_seen, 4'ha);
    endtask : t_sel_on_fault

    task t_out_loss;
        apb(1'b1, `ADDR_CTRL, 32'h1);
        out_lost <= 1'b1;
        waitc(10);
        check("out_off", trip, 1'b0);
        apb(1'b1, `ADDR_CTRL, 32'h5);
        waitc(6);
        check("out_trip", trip, 1'b1);
        check("out_code", code_seen, 4'hf);
        clear_fault();
    endtask : t_out_loss

    task t_in_loss;
        in_lost <= 3'b100;
        waitc(40);
        check("in_off", trip, 1'b0);
        clear_fault();
        apb(1'b1, `ADDR_CTRL, 32'hd);
        in_lost <= 3'b100;
        waitc(14);
        check("in_early", trip, 1'b0);
        waitc(10);
        check("in_trip", trip, 1'b1);
        clear_fault();
        apb(1'b1, `ADDR_CTRL, 32'h1d);
        in_lost <= 3'b001;
        waitc(24);
        check("pf_decel", decel, 1'b1);
        check("pf_notrip", trip, 1'b0);
        clear_fault();
        apb(1'b1, `ADDR_CTRL, 32'hd);
        in_lost <= 3'b011;
        waitc(24);
        check("shutoff", shutoff, 1'b1);
        check("shut_notrip", trip, 1'b0);
        in_lost <= 3'b000;
        waitc(5);
        check("shut_end", shutoff, 1'b0);
        clear_fault();
    endtask : t_in_loss

    task t_irq;
        apb(1'b1, `ADDR_INT_MASK, 32'h1e);
        apb(1'b1, `ADDR_INT_STAT, 32'h1f);
        fault <= 16'h0001;
        waitc(5);
        check("irq_masked", irq, 1'b0);
        apb(1'b1, `ADDR_INT_MASK, 32'h01);
        waitc(3);
        check("irq_on", irq, 1'b1);
        apb(1'b0, `ADDR_INT_STAT, 32'h0);
        check("int_stat", rd, 32'h1);
        clear_fault();
        apb(1'b1, `ADDR_INT_STAT, 32'h1);
        waitc(3);
        check("irq_clr", irq, 1'b0);
        apb(1'b0, 8'h20, 32'h0);
        check("unmapped_err", err, 1'b1);
        check("unmapped_rd", rd, 32'h0);
    endtask : t_irq

    initial
    begin
        rst_i    = 1'b1;
        psel     = 1'b0;
        pen      = 1'b0;
        pwr      = 1'b0;
        paddr    = 8'h0;
        pwdata   = 32'h0;
        fault    = 16'h0;
        normal   = 4'h0;
        out_lost = 1'b0;
        in_lost  = 3'h0;
        waitc(4);
        rst_i <= 1'b0;
        t_sel_off();
        t_map();
        t_sel_on_fault();
        t_out_loss();
        t_in_loss();
        t_irq();
        tally_and_finish();
    end
endmodule : test_fault_code_output
